// file: osc_pkg.sv
// Package: constants and types of the OTP security controller
//
// Summary of operation
// - The array is 8 KB split into four sectors of 512 rows, each row 32 bits.
// - At power-up the security register is loaded from the array first.
// - The first COPY_WORDS rows from row 0 are copied into tile SRAM, then run.
// - The row address comes through a 16-bit port with resource 0x100200.
// - Program data comes through a 32-bit port with resource 0x200100.
// - Operations are controlled through a 16-bit port with resource 0x100300.
// - Security bit 0 blocks all JTAG access to tile state and memory.
// - Security bit 1 blocks other tiles reaching this processor via switch.
// - Security bit 5 bypasses boot ROM and starts from array address 0.
// - Security bit 7 enables the redundant rows of the array.
// - Security bits 8 to 11 each lock sector 0 to 3 against programming.
// - Security bit 12 rejects every array write, security row included.
// - Security bit 13 denies JTAG all read and write access to the array.
// - Security bit 14 disables the multiprocessor debug sync pin.
// - Security bits 15 to 21 are general purpose bits for software.
// - Security bits 22 to 31 extend the JTAG user code.
package osc_pkg;
  localparam int ROWS_PER_SECTOR = 512;
  localparam int SECTORS = 4;
  localparam int ROW_W = 32;
  localparam int ROW_AW = 11;
  // I/O port resource numbers
  localparam logic [31:0] RES_ADDR_PORT = 32'h0010_0200;
  localparam logic [31:0] RES_DATA_PORT = 32'h0020_0100;
  localparam logic [31:0] RES_CTRL_PORT = 32'h0010_0300;
  // Security bit positions
  localparam int SB_NO_JTAG = 0;
  localparam int SB_NO_LINK = 1;
  localparam int SB_SEC_BOOT = 5;
  localparam int SB_REDUND = 7;
  localparam int SB_LOCK0 = 8;
  localparam int SB_MASTER = 12;
  localparam int SB_NO_JOTP = 13;
  localparam int SB_NO_DBG = 14;
  localparam int SB_GP_LO = 15;
  localparam int SB_GP_HI = 21;
  localparam int SB_UID_LO = 22;
  localparam int SB_UID_HI = 31;
  localparam logic [31:0] SEC_VALID_MASK = 32'hffff_ffa3;
  localparam logic [31:0] SEC_GP_MASK = 32'h003f_8000;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  // Row that holds the security word: last row of sector 3
  localparam logic [10:0] SEC_ROW = 11'h7ff;
  // APB byte addresses
  localparam logic [11:0] A_ADDR = 12'h000;
  localparam logic [11:0] A_DATA = 12'h004;
  localparam logic [11:0] A_CTRL = 12'h008;
  localparam logic [11:0] A_SEC = 12'h00c;
  localparam logic [11:0] A_STAT = 12'h010;
  localparam logic [11:0] A_RDATA = 12'h014;
  // Control port commands
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_PROG = 2'h2;
  localparam logic [1:0] CMD_SECW = 2'h3;
  // Program pulse, 10 us at 50 MHz
  localparam int PROG_NS = 10000;
  localparam int CLK_NS = 20;
  localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
  typedef enum {ST_LOADSEC, ST_COPY, ST_IDLE, ST_RD, ST_PROG, ST_DONE} osc_state_t;
endpackage : osc_pkg

// file: osc_mem_if.sv
// Interface: array port between controller and OTP storage
`timescale 1ns/1ps
interface osc_mem_if;
  logic we;
  logic [10:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : osc_mem_if

// file: osc_otp_array.sv
// OTP storage model: programming only sets bits, read data registered
`timescale 1ns/1ps
module osc_otp_array #(
  parameter int DEPTH = 2048
) (
  input wire logic clock,
  osc_mem_if.mem port
);
  import osc_pkg::*;
  logic [31:0] cells [DEPTH];
  // Fuses only ever blow, so writes OR into the row
  // Plain always: contents may also be preloaded from outside
  always @(posedge clock) begin
    if (port.we) begin
      cells[port.addr] <= cells[port.addr] | port.wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clock) begin
    port.rdata <= cells[port.addr];
  end
endmodule : osc_otp_array

// file: osc_ctrl.sv
// OTP security controller with APB register access
`timescale 1ns/1ps
module osc_ctrl #(
  parameter int COPY_WORDS = 8,
  parameter int PROG_CYCLES = osc_pkg::PROG_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic jtagOtpReq,
  output logic jtagEnable,
  output logic linkEnable,
  output logic bootFromOtp,
  output logic redundEnable,
  output logic debugPinEnable,
  output logic [9:0] userCodeExt,
  output logic sramWe,
  output logic [10:0] sramAddr,
  output logic [31:0] sramData,
  output logic bootReady
);
  import osc_pkg::*;

  osc_mem_if mem ();
  osc_otp_array #(.DEPTH(SECTORS * ROWS_PER_SECTOR)) uArray (
    .clock(clock),
    .port(mem)
  );

  osc_state_t state_r;
  logic [31:0] sec_r;
  logic [15:0] addrPort_r;
  logic [31:0] dataPort_r;
  logic [15:0] ctrlPort_r;
  logic [31:0] rdata_r;
  logic [10:0] ptr_r;
  logic [15:0] cnt_r;
  logic busy_r;
  logic refused_r;
  logic waitRd_r;
  logic memWe_r;
  logic jtagOtpSync1_r;
  logic jtagOtpSync2_r;
  logic jtagOtpDenied_r;

  // Array port driven from registers
  assign mem.we = memWe_r;
  assign mem.addr = (state_r == ST_IDLE || state_r == ST_RD ||
    state_r == ST_PROG) ? addrPort_r[10:0] : ptr_r;
  assign mem.wdata = dataPort_r;

  logic wrEn;
  logic rdEn;
  logic [1:0] cmd;
  logic [1:0] sector;
  logic locked;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign cmd = ctrlPort_r[1:0];
  assign sector = addrPort_r[10:9];
  // Master lock covers all, else per sector lock
  assign locked = sec_r[SB_MASTER] || sec_r[SB_LOCK0 + 32'(sector)];

  // Sequencer: security load, boot copy, then command service
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_LOADSEC;
      ptr_r <= SEC_ROW;
      cnt_r <= 16'h0000;
      waitRd_r <= 1'b0;
    end else begin
      case (state_r)
        ST_LOADSEC: begin
          waitRd_r <= 1'b1;
          if (waitRd_r) begin
            waitRd_r <= 1'b0;
            ptr_r <= 11'h000;
            state_r <= ST_COPY;
          end
        end
        ST_COPY: begin
          // One step past the last row so its word still reaches SRAM
          if (ptr_r == 11'(COPY_WORDS)) begin
            state_r <= ST_IDLE;
          end else begin
            ptr_r <= ptr_r + 11'h001;
          end
          waitRd_r <= 1'b1;
        end
        ST_IDLE: begin
          cnt_r <= 16'h0000;
          if (wrEn && paddr == A_CTRL && pwdata[1:0] == CMD_READ) begin
            state_r <= ST_RD;
          end else if (wrEn && paddr == A_CTRL &&
              (pwdata[1:0] == CMD_PROG || pwdata[1:0] == CMD_SECW) &&
              !sec_r[SB_MASTER]) begin
            state_r <= ST_PROG;
          end
        end
        ST_RD: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'h0001) begin
            state_r <= ST_DONE;
          end
        end
        ST_PROG: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'(PROG_CYCLES - 1)) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Write strobe to array held one cycle; row programs obey all locks, security writes only the master lock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      memWe_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      memWe_r <= 1'b0;
      if (state_r == ST_PROG && cnt_r == 16'h0000) begin
        if (cmd == CMD_PROG && !locked) begin
          memWe_r <= 1'b1;
        end else if (cmd == CMD_SECW && !sec_r[SB_MASTER]) begin
          memWe_r <= 1'b1;
        end else begin
          refused_r <= 1'b1;
        end
      end
      // Set wins over a clear in the same cycle
      if (wrEn && paddr == A_STAT && pwdata[1] &&
          !(state_r == ST_PROG && cnt_r == 16'h0000)) begin
        refused_r <= 1'b0;
      end
      if (wrEn && paddr == A_CTRL && pwdata[1:0] != CMD_READ &&
          pwdata[1:0] != 2'h0 && state_r == ST_IDLE &&
          sec_r[SB_MASTER]) begin
        refused_r <= 1'b1;
      end
    end
  end

  // Port registers written by the core
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      addrPort_r <= 16'h0000;
      dataPort_r <= 32'h0000_0000;
      ctrlPort_r <= 16'h0000;
    end else if (wrEn && state_r == ST_IDLE) begin
      if (paddr == A_ADDR) addrPort_r <= pwdata[15:0];
      if (paddr == A_DATA) dataPort_r <= pwdata;
      if (paddr == A_CTRL) ctrlPort_r <= pwdata[15:0];
    end
  end

  // Security register: loaded at boot, updated after security write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sec_r <= SEC_RESET;
    end else if (state_r == ST_LOADSEC && waitRd_r) begin
      sec_r <= mem.rdata & SEC_VALID_MASK;
    end else if (memWe_r && cmd == CMD_SECW) begin
      sec_r <= (sec_r | dataPort_r) & SEC_VALID_MASK;
    end else if (wrEn && paddr == A_SEC) begin
      // Software may only touch the general purpose field
      sec_r <= (sec_r & ~SEC_GP_MASK) | (pwdata & SEC_GP_MASK);
    end
  end

  // Read data latch for the core and for the boot copy
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0000_0000;
      sramWe <= 1'b0;
      sramAddr <= 11'h000;
      sramData <= 32'h0000_0000;
    end else begin
      sramWe <= state_r == ST_COPY && waitRd_r;
      sramAddr <= ptr_r - 11'h001;
      sramData <= mem.rdata;
      if (state_r == ST_RD && cnt_r == 16'h0001) begin
        rdata_r <= mem.rdata;
      end
    end
  end

  // Pin side JTAG OTP request crosses in through two flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      jtagOtpSync1_r <= 1'b0;
      jtagOtpSync2_r <= 1'b0;
      jtagOtpDenied_r <= 1'b0;
    end else begin
      jtagOtpSync1_r <= jtagOtpReq;
      jtagOtpSync2_r <= jtagOtpSync1_r;
      jtagOtpDenied_r <= jtagOtpSync2_r &&
        (sec_r[SB_NO_JOTP] || sec_r[SB_NO_JTAG]);
    end
  end

  // Protection outputs, all registered
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      jtagEnable <= 1'b0;
      linkEnable <= 1'b0;
      bootFromOtp <= 1'b0;
      redundEnable <= 1'b0;
      debugPinEnable <= 1'b0;
      userCodeExt <= 10'h000;
      bootReady <= 1'b0;
      busy_r <= 1'b1;
    end else begin
      // Held off until security word is in place
      jtagEnable <= state_r != ST_LOADSEC && !sec_r[SB_NO_JTAG];
      linkEnable <= state_r != ST_LOADSEC && !sec_r[SB_NO_LINK];
      bootFromOtp <= sec_r[SB_SEC_BOOT];
      redundEnable <= sec_r[SB_REDUND];
      debugPinEnable <= state_r != ST_LOADSEC &&
        !sec_r[SB_NO_DBG];
      userCodeExt <= sec_r[SB_UID_HI:SB_UID_LO];
      bootReady <= state_r != ST_LOADSEC && state_r != ST_COPY;
      busy_r <= state_r != ST_IDLE;
    end
  end

  // APB: zero wait state, error on unmapped address
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == A_ADDR ||
        paddr == A_DATA || paddr == A_CTRL || paddr == A_SEC ||
        paddr == A_STAT || paddr == A_RDATA);
      case (paddr)
        A_ADDR: prdata <= {16'h0000, addrPort_r};
        A_DATA: prdata <= dataPort_r;
        A_CTRL: prdata <= {16'h0000, ctrlPort_r};
        A_SEC: prdata <= sec_r;
        A_STAT: prdata <= {29'h0, jtagOtpDenied_r, refused_r, busy_r};
        A_RDATA: prdata <= rdata_r;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  a_sec_masked: assert property (@(posedge clock) disable iff (!nrst)
    (sec_r & ~SEC_VALID_MASK) == 32'h0)
    else $error("unassigned security bit set");
  a_master_lock: assert property (@(posedge clock) disable iff (!nrst)
    sec_r[SB_MASTER] |-> !memWe_r)
    else $error("write under master lock");
  a_sector_lock: assert property (@(posedge clock) disable iff (!nrst)
    memWe_r && cmd == CMD_PROG |-> !locked)
    else $error("write to locked sector");
  a_jtag_gate: assert property (@(posedge clock) disable iff (!nrst)
    sec_r[SB_NO_JTAG] && $stable(sec_r) |=> !jtagEnable)
    else $error("jtag not blocked");
  a_link_gate: assert property (@(posedge clock) disable iff (!nrst)
    sec_r[SB_NO_LINK] && $stable(sec_r) |=> !linkEnable)
    else $error("link not blocked");
  a_boot_otp: assert property (@(posedge clock) disable iff (!nrst)
    $stable(sec_r) |=> bootFromOtp == $past(sec_r[SB_SEC_BOOT]))
    else $error("boot source wrong");
  a_redund_rows: assert property (@(posedge clock) disable iff (!nrst)
    $stable(sec_r) |=> redundEnable == $past(sec_r[SB_REDUND]))
    else $error("redundant rows wrong");
  a_debug_pin: assert property (@(posedge clock) disable iff (!nrst)
    sec_r[SB_NO_DBG] && $stable(sec_r) |=> !debugPinEnable)
    else $error("debug pin not blocked");
  a_jtag_otp: assert property (@(posedge clock) disable iff (!nrst)
    sec_r[SB_NO_JOTP] && jtagOtpSync2_r |=> jtagOtpDenied_r)
    else $error("jtag otp not denied");
  a_apb_ready: assert property (@(posedge clock) disable iff (!nrst)
    psel && !penable |=> pready)
    else $error("apb ready late");
  a_prot_off_load: assert property (@(posedge clock) disable iff (!nrst)
    state_r == ST_LOADSEC |=> !jtagEnable)
    else $error("jtag open before load");

  // Counts copy strobes so the boot copy length can be checked
  logic [11:0] copyCnt_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      copyCnt_r <= 12'h000;
    end else if (sramWe) begin
      copyCnt_r <= copyCnt_r + 12'h001;
    end
  end

  // Boot sequencing, lock, user code and APB ready checks
  a_copy_length: assert property (@(posedge clock) disable iff (!nrst)
    $rose(bootReady) |-> copyCnt_r == 12'(COPY_WORDS))
    else $error("boot copy length wrong");
  a_copy_order: assert property (@(posedge clock) disable iff (!nrst)
    sramWe |-> sramAddr == copyCnt_r[10:0])
    else $error("boot copy out of order");
  a_no_write_load: assert property (@(posedge clock) disable iff (!nrst)
    state_r == ST_LOADSEC || state_r == ST_COPY |-> !memWe_r)
    else $error("array write during boot");
  a_idle_quiet: assert property (@(posedge clock) disable iff (!nrst)
    state_r == ST_IDLE |-> !memWe_r)
    else $error("array write while idle");
  a_sec_gp_only: assert property (@(posedge clock) disable iff (!nrst)
    wrEn && paddr == A_SEC && state_r != ST_LOADSEC && !memWe_r
    |=> (sec_r & ~SEC_GP_MASK) == ($past(sec_r) & ~SEC_GP_MASK))
    else $error("software touched fixed security bits");
  a_user_code: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> userCodeExt == $past(sec_r[SB_UID_HI:SB_UID_LO]))
    else $error("user code extension wrong");
  a_lock_refused: assert property (@(posedge clock) disable iff (!nrst)
    state_r == ST_PROG && cnt_r == 16'h0000 && cmd == CMD_PROG && locked
    |=> refused_r && !memWe_r)
    else $error("locked sector not refused");
  a_master_refused: assert property (@(posedge clock) disable iff (!nrst)
    wrEn && paddr == A_CTRL && state_r == ST_IDLE && sec_r[SB_MASTER] &&
    (pwdata[1:0] == CMD_PROG || pwdata[1:0] == CMD_SECW)
    |=> refused_r && state_r == ST_IDLE)
    else $error("master lock not refused");
  a_ready_pulse: assert property (@(posedge clock) disable iff (!nrst)
    pready |=> !pready)
    else $error("ready held too long");

  c_prog: cover property (@(posedge clock) disable iff (!nrst) memWe_r);
  c_refuse: cover property (@(posedge clock) disable iff (!nrst)
    $rose(refused_r));
  c_copy_done: cover property (@(posedge clock) disable iff (!nrst)
    $rose(bootReady));
  c_sec_write: cover property (@(posedge clock) disable iff (!nrst)
    memWe_r && cmd == CMD_SECW);
  c_jtag_denied: cover property (@(posedge clock) disable iff (!nrst)
    $rose(jtagOtpDenied_r));
endmodule : osc_ctrl

// file: osc_sram_model.sv
// Partner model: tile SRAM that receives the boot copy
`timescale 1ns/1ps
module osc_sram_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sramWe,
  input wire logic [10:0] sramAddr,
  input wire logic [31:0] sramData
);
  logic [31:0] mem [2048];
  int writes;

  // Store each copied word; the count restarts with every boot
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      writes <= 0;
    end else if (sramWe === 1'b1) begin
      mem[sramAddr] <= sramData;
      writes <= writes + 1;
    end
  end
endmodule : osc_sram_model

// file: osc_ctrl_bench.sv
// Self-checking bench for the OTP security controller
`timescale 1ns/1ps
module osc_ctrl_bench;
  import osc_pkg::*;
  localparam int NCOPY = 8;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic jtagOtpReq = 1'b0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, jtagEnable, linkEnable, bootFromOtp;
  logic redundEnable, debugPinEnable, sramWe, bootReady;
  logic [9:0] userCodeExt;
  logic [10:0] sramAddr;
  logic [31:0] sramData, s;
  logic [31:0] tbl [10] = '{32'h0, 32'hffff_ffff, 32'h1, 32'h2, 32'h20,
    32'h80, 32'h4000, 32'hffc0_0000, 32'h5c, 32'h2000};
  int errors = 0;
  int tests_run = 0;
  int sct;
  logic [10:0] freeRow;

  always #10 clock = ~clock;

  osc_ctrl #(.COPY_WORDS(NCOPY), .PROG_CYCLES(4)) osc_ctrl_inst (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .jtagOtpReq(jtagOtpReq),
    .jtagEnable(jtagEnable), .linkEnable(linkEnable),
    .bootFromOtp(bootFromOtp), .redundEnable(redundEnable),
    .debugPinEnable(debugPinEnable), .userCodeExt(userCodeExt),
    .sramWe(sramWe), .sramAddr(sramAddr), .sramData(sramData),
    .bootReady(bootReady));

  osc_sram_model osc_sram_model_inst (.clock(clock), .nrst(nrst),
    .sramWe(sramWe), .sramAddr(sramAddr), .sramData(sramData));

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic timeout();
    errors++;
    $display("wait ran out at %0t", $time);
    give_verdict();
  endtask : timeout

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (k == 50) timeout();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdv(input logic [11:0] a, output logic [31:0] rd);
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
  endtask : rdv

  // Busy may rise a cycle late, so let it settle before polling
  task automatic otp_op(input logic [10:0] row, input logic [31:0] d,
      input logic [1:0] cmd);
    logic [31:0] st;
    int k;
    wr(A_ADDR, {21'h0, row});
    wr(A_DATA, d);
    wr(A_CTRL, {30'h0, cmd});
    repeat (2) @(posedge clock);
    for (k = 0; k < 100; k++) begin
      rdv(A_STAT, st);
      if (st[0] === 1'b0) break;
    end
    if (k == 100) timeout();
  endtask : otp_op

  // Preload the array under reset, release, wait for the boot copy
  task automatic boot(input logic [31:0] sec);
    int i;
    @(posedge clock);
    nrst <= 1'b0;
    for (i = 0; i < 2048; i++) begin
      osc_ctrl_inst.uArray.cells[i] = (i < NCOPY) ? 32'h1000_0000 + i : 0;
    end
    osc_ctrl_inst.uArray.cells[SEC_ROW] = sec;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    for (i = 0; i < 300; i++) begin
      @(posedge clock);
      if (bootReady === 1'b1) break;
    end
    if (i == 300) timeout();
  endtask : boot

  initial begin
    // Security word decode after each power-up
    foreach (tbl[i]) begin
      boot(tbl[i]);
      s = tbl[i];
      check({17'h0, jtagEnable, linkEnable, bootFromOtp, redundEnable,
        debugPinEnable, userCodeExt}, {17'h0, ~s[0], ~s[1], s[5], s[7],
        ~s[14], s[31:22]});
      rdv(A_SEC, r);
      check(r, s & SEC_VALID_MASK);
      jtagOtpReq <= 1'b1;
      repeat (4) @(posedge clock);
      rdv(A_STAT, r);
      check({31'h0, r[2]}, {31'h0, s[13] | s[0]});
      jtagOtpReq <= 1'b0;
    end
    check(32'(osc_sram_model_inst.writes), NCOPY);
    for (int i = 0; i < NCOPY; i++) begin
      check(osc_sram_model_inst.mem[i], 32'h1000_0000 + i);
    end
    $display("test boot decode done");
    // Each sector lock refuses its own first row but not row 512 (sector 0 lock) or the last row of the previous sector (other locks)
    for (sct = 0; sct < 4; sct++) begin
      boot(32'h100 << sct);
      otp_op(11'(sct * 512), 32'hff, CMD_PROG);
      rdv(A_STAT, r);
      check({31'h0, r[1]}, 32'h1);
      wr(A_STAT, 32'h2);
      rdv(A_STAT, r);
      check({31'h0, r[1]}, 32'h0);
      otp_op(11'(sct * 512), 32'h0, CMD_READ);
      rdv(A_RDATA, r);
      // Row 0 of sector 0 still holds its boot word
      check(r, (sct == 0) ? 32'h1000_0000 : 32'h0);
      freeRow = (sct == 0) ? 11'd512 : 11'(sct * 512 - 1);
      otp_op(freeRow, 32'hff, CMD_PROG);
      otp_op(freeRow, 32'h0, CMD_READ);
      rdv(A_RDATA, r);
      check(r, 32'hff);
    end
    $display("test sector locks done");
    // Master lock stops rows and the security word alike
    boot(32'h1000);
    otp_op(11'h0, 32'h0f0f_0f0f, CMD_PROG);
    otp_op(SEC_ROW, 32'h1, CMD_SECW);
    rdv(A_STAT, r);
    check({31'h0, r[1]}, 32'h1);
    check({31'h0, jtagEnable}, 32'h1);
    otp_op(11'h0, 32'h0, CMD_READ);
    rdv(A_RDATA, r);
    check(r, 32'h1000_0000);
    $display("test master lock done");
    // Security program, then the software bits
    boot(32'h0);
    otp_op(SEC_ROW, 32'h2, CMD_SECW);
    check({31'h0, linkEnable}, 32'h0);
    rdv(A_SEC, r);
    check(r, 32'h2);
    wr(A_SEC, 32'hffff_ffff);
    rdv(A_SEC, r);
    check(r, 32'h2 | SEC_GP_MASK);
    apb(1'b0, 12'h018, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    $display("test security write done");
    give_verdict();
  end
endmodule : osc_ctrl_bench
